//--- logic/mlsp_pkg.sv
`default_nettype none
package mlsp_pkg;

   typedef enum logic [1:0] {
      BUILD_STD  = 2'b00,
      BUILD_DUAL = 2'b01,
      BUILD_QUAD = 2'b10
   } build_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP   = 2'b10
   } engine_state_t;

   localparam int BYTE_W       = 8;
   localparam int NUM_LANES    = 4;
   localparam int MAX_SLAVES   = 32;
   localparam int DEPTH_NONE   = 0;
   localparam int DEPTH_SMALL  = 16;
   localparam int DEPTH_LARGE  = 256;

   // Serial clock half period floor, in system clocks
   localparam logic [7:0] MIN_HALF_PERIOD = 8'h04;

   localparam logic [2:0] LANES_1 = 3'h1;
   localparam logic [2:0] LANES_2 = 3'h2;
   localparam logic [2:0] LANES_4 = 3'h4;

   // Lane enables are active low: a 0 drives the lane
   localparam logic [3:0] OE_ALL_RELEASED = 4'hf;
   localparam logic [3:0] OE_LANE0        = 4'he;
   localparam logic [3:0] OE_LANE1        = 4'hd;
   localparam logic [3:0] OE_DUAL         = 4'hc;
   localparam logic [3:0] OE_QUAD         = 4'h0;

   localparam logic [7:0] CMD_DUAL_OUT_READ  = 8'h3b;
   localparam logic [7:0] CMD_QUAD_OUT_READ  = 8'h6b;
   localparam logic [7:0] CMD_DUAL_IO_READ   = 8'hbb;
   localparam logic [7:0] CMD_QUAD_IO_READ   = 8'heb;
   localparam logic [7:0] CMD_QUAD_PROGRAM   = 8'h32;

   typedef struct packed {
      logic [2:0] lanes;
      logic       addr_multi;
      logic       is_read;
   } lane_plan_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe_n;
   } lane_drive_t;

   function automatic lane_plan_t decode_cmd(input logic [7:0] cmd);
      lane_plan_t p;
      p = '{lanes: LANES_1, addr_multi: 1'b0, is_read: 1'b0};
      case (cmd)
         CMD_DUAL_OUT_READ: p = '{lanes: LANES_2, addr_multi: 1'b0, is_read: 1'b1};
         CMD_QUAD_OUT_READ: p = '{lanes: LANES_4, addr_multi: 1'b0, is_read: 1'b1};
         CMD_DUAL_IO_READ:  p = '{lanes: LANES_2, addr_multi: 1'b1, is_read: 1'b1};
         CMD_QUAD_IO_READ:  p = '{lanes: LANES_4, addr_multi: 1'b1, is_read: 1'b1};
         CMD_QUAD_PROGRAM:  p = '{lanes: LANES_4, addr_multi: 1'b0, is_read: 1'b0};
         default:           p = '{lanes: LANES_1, addr_multi: 1'b0, is_read: 1'b0};
      endcase
      return p;
   endfunction

   function automatic logic [3:0] lane_oe_for(input logic [2:0] lanes, input logic drive);
      logic [3:0] oe;
      oe = OE_LANE0;
      if (drive) begin
         if (lanes == LANES_4) oe = OE_QUAD;
         else if (lanes == LANES_2) oe = OE_DUAL;
      end else if (lanes != LANES_1) begin
         oe = OE_ALL_RELEASED;
      end
      return oe;
   endfunction

endpackage
`default_nettype wire

//--- logic/mlsp_fifo.sv
`default_nettype none
module mlsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_wr_valid,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output logic                  o_wr_ready,
   output logic                  o_rd_valid,
   output logic      [WIDTH-1:0] o_rd_data,
   input  wire logic             i_rd_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0]   FULL_COUNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             full, next_full, empty, next_empty;
   logic             do_wr, do_rd;

   always_comb begin
      do_wr       = i_wr_valid && !full;
      do_rd       = i_rd_ready && !empty;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (do_wr) begin
         next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
         next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) next_count = count + 1'b1;
      else if (do_rd && !do_wr) next_count = count - 1'b1;
      next_full  = (next_count == FULL_COUNT);
      next_empty = (next_count == '0);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
         full   <= 1'b0;
         empty  <= 1'b1;
         o_wr_ready <= 1'b1;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
         full   <= next_full;
         empty  <= next_empty;
         o_wr_ready <= !next_full;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (do_wr) mem[wr_ptr] <= i_wr_data;
   end

   assign o_rd_valid = !empty;
   assign o_rd_data  = mem[rd_ptr];
endmodule
`default_nettype wire

//--- logic/mlsp_two_entry_buffer.sv
`default_nettype none
module mlsp_two_entry_buffer #(
   parameter int WIDTH = 8
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   logic [WIDTH-1:0] skid_data, next_skid_data, next_out_data;
   logic             skid_valid, next_skid_valid, next_out_valid, in_fire;

   always_comb begin
      in_fire         = i_in_valid && o_in_ready;
      next_out_valid  = o_out_valid;
      next_out_data   = o_out_data;
      next_skid_valid = skid_valid;
      next_skid_data  = skid_data;
      if (!o_out_valid || i_out_ready) begin
         // Output slot frees: skid entry goes first to keep order
         next_out_valid  = skid_valid || in_fire;
         next_out_data   = skid_valid ? skid_data : i_in_data;
         next_skid_valid = 1'b0;
      end else if (in_fire) begin
         next_skid_valid = 1'b1;
         next_skid_data  = i_in_data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_out_valid <= 1'b0;
         o_out_data  <= '0;
         skid_valid  <= 1'b0;
         skid_data   <= '0;
         o_in_ready  <= 1'b1;
      end else begin
         o_out_valid <= next_out_valid;
         o_out_data  <= next_out_data;
         skid_valid  <= next_skid_valid;
         skid_data   <= next_skid_data;
         o_in_ready  <= !next_skid_valid;
      end
   end
endmodule
`default_nettype wire

//--- logic/multi_lane_serial_port_ctrl.sv
// How it works
// - Software sets serial clock phase and idle polarity.
// - Standard mode is full duplex over receive, transmit, clock, select.
// - Manual select: outputs follow the select value, no toggling between elements.
// - Automatic select toggles the active select after each element.
// - Automatic select exists only in standard single-lane builds.
// - Standard FIFO depth is 0, 16 or 256; zero means single registers.
// - Standard FIFO width equals the transaction width.
// - Master shifts elements back to back while transmit data waits and the receive FIFO has room.
// - Slave aborts the element when select rises mid-element.
// - Aborted slave element is sent again from its start.
// - Slave operation only in standard builds; dual and quad are master only.
// - Dual and quad builds always have FIFOs of 16 or 256.
// - Dual and quad elements are one byte; FIFO entries are XFER_WIDTH bits wide.
// - Dual: lanes 0 and 1 fixed for single-lane, bidirectional per command.
// - Quad build: lanes 2 and 3 released during dual-lane commands.
// - Quad build: quad commands drive or release all four lanes in the data phase.
// - Command byte sets lane count and directions; single-lane commands still work.
// - Individually decoded select outputs for up to 32 slaves.
// - Dual and quad transfers are MSB first, one byte long.
`default_nettype none
module multi_lane_serial_port_ctrl #(
   parameter mlsp_pkg::build_mode_t BUILD      = mlsp_pkg::BUILD_STD,
   parameter int                    FIFO_DEPTH = mlsp_pkg::DEPTH_SMALL,
   parameter int                    XFER_WIDTH = mlsp_pkg::BYTE_W,
   parameter int                    NUM_SLAVES = 1
) (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_enable,
   input  wire logic                        i_master,
   input  wire logic                        i_cpol,
   input  wire logic                        i_cpha,
   input  wire logic                        i_manual_ss,
   input  wire logic [NUM_SLAVES-1:0]       i_ss_value,
   input  wire logic [7:0]                  i_half_period,
   input  wire logic [2:0]                  i_addr_bytes,
   input  wire logic                        i_tx_valid,
   input  wire logic [XFER_WIDTH-1:0]       i_tx_data,
   output logic                             o_tx_ready,
   output logic                             o_rx_valid,
   output logic      [XFER_WIDTH-1:0]       o_rx_data,
   input  wire logic                        i_rx_ready,
   output logic                             o_busy,
   output logic                             o_tx_empty,
   output logic                             o_slave_abort,
   output logic                             o_sclk,
   output logic      [NUM_SLAVES-1:0]       o_ss_n,
   input  wire logic                        i_sclk,
   input  wire logic                        i_slave_select_input_n,
   input  wire logic [3:0]                  i_serial_lane,
   output var mlsp_pkg::lane_drive_t        o_serial_lane
);
   localparam bit IS_STD = (BUILD == mlsp_pkg::BUILD_STD);
   // Element width: transaction width in standard, one byte otherwise
   localparam int EW = IS_STD ? XFER_WIDTH : mlsp_pkg::BYTE_W;
   localparam int TX_SHIFT = XFER_WIDTH - EW;
   localparam int DEPTH = (!IS_STD && FIFO_DEPTH == mlsp_pkg::DEPTH_NONE) ?
                          mlsp_pkg::DEPTH_SMALL :
                          ((FIFO_DEPTH == mlsp_pkg::DEPTH_NONE) ? 1 : FIFO_DEPTH);
   localparam logic [XFER_WIDTH-1:0] EW_MASK = {XFER_WIDTH{1'b1}} >> TX_SHIFT;
   localparam logic [6:0] BEATS2_1 = 7'(2 * EW);
   localparam logic [6:0] BEATS2_2 = 7'(EW);
   localparam logic [6:0] BEATS2_4 = 7'(EW / 2);
   localparam int NSYNC = 6;

   // Two-stage synchronisers for every pin input
   logic [NSYNC-1:0] pin_in, sync1, sync2;
   assign pin_in = {i_slave_select_input_n, i_sclk, i_serial_lane};

   generate
      for (genvar g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               sync1[g] <= 1'b1;
               sync2[g] <= 1'b1;
            end else begin
               sync1[g] <= pin_in[g];
               sync2[g] <= sync1[g];
            end
         end
      end
   endgenerate

   logic [3:0] lane_in;
   logic       sclk_s, sel;
   assign lane_in = sync2[3:0];
   assign sclk_s  = sync2[4];
   assign sel     = !sync2[5];

   // Transmit and receive FIFOs
   logic                  tx_pop, tx_valid, rx_push, rx_room;
   logic                  rx_mid_valid, rx_mid_ready;
   logic [XFER_WIDTH-1:0] tx_head, rx_word, rx_mid_data;

   mlsp_fifo #(.WIDTH(XFER_WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
      .i_sys_clk  (i_sys_clk),
      .i_rst_n    (i_rst_n),
      .i_wr_valid (i_tx_valid),
      .i_wr_data  (i_tx_data),
      .o_wr_ready (o_tx_ready),
      .o_rd_valid (tx_valid),
      .o_rd_data  (tx_head),
      .i_rd_ready (tx_pop)
   );

   mlsp_fifo #(.WIDTH(XFER_WIDTH), .DEPTH(DEPTH)) u_receive_data_fifo (
      .i_sys_clk  (i_sys_clk),
      .i_rst_n    (i_rst_n),
      .i_wr_valid (rx_push),
      .i_wr_data  (rx_word),
      .o_wr_ready (rx_room),
      .o_rd_valid (rx_mid_valid),
      .o_rd_data  (rx_mid_data),
      .i_rd_ready (rx_mid_ready)
   );

   mlsp_two_entry_buffer #(.WIDTH(XFER_WIDTH)) u_rx_buffer (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (rx_mid_valid),
      .i_in_data   (rx_mid_data),
      .o_in_ready  (rx_mid_ready),
      .o_out_valid (o_rx_valid),
      .o_out_data  (o_rx_data),
      .i_out_ready (i_rx_ready)
   );

   // Shift engine state
   mlsp_pkg::engine_state_t state, next_state;
   mlsp_pkg::lane_plan_t    plan, next_plan;
   logic [XFER_WIDTH-1:0]   shift_tx, next_shift_tx, shift_rx, next_shift_rx;
   logic [6:0]              edge_cnt, next_edge_cnt, target, beats2;
   logic [7:0]              half_cnt, next_half_cnt, half;
   logic [2:0]              lanes, next_lanes, elem_idx, next_elem_idx;
   logic [3:0]              lane_oe_n, next_lane_oe_n, lane_out, next_lane_out, in_bits;
   logic [NUM_SLAVES-1:0]   ss_out, next_ss_out;
   logic                    sclk, next_sclk, sclk_d, next_sclk_d, cmd_seen, next_cmd_seen;
   logic                    busy, next_busy, tx_empty, next_tx_empty, abort, next_abort;
   logic                    slave_mode, auto_ss, ev, lead, sample;

   always_comb begin
      slave_mode = IS_STD && !i_master;
      auto_ss    = IS_STD && !i_manual_ss && !slave_mode;
      half       = (i_half_period < mlsp_pkg::MIN_HALF_PERIOD) ?
                   mlsp_pkg::MIN_HALF_PERIOD : i_half_period;
      next_state     = state;
      next_plan      = plan;
      next_shift_tx  = shift_tx;
      next_shift_rx  = shift_rx;
      next_edge_cnt  = edge_cnt;
      next_half_cnt  = half_cnt;
      next_lanes     = lanes;
      next_elem_idx  = elem_idx;
      next_lane_oe_n = lane_oe_n;
      next_sclk      = sclk;
      next_sclk_d    = sclk_s;
      next_cmd_seen  = cmd_seen;
      next_abort     = 1'b0;
      tx_pop         = 1'b0;
      rx_push        = 1'b0;
      // Edge events: own divider as master, synchronised pin as slave
      if (slave_mode) begin
         ev   = (state == mlsp_pkg::ST_SHIFT) && (sclk_s != sclk_d);
         lead = sclk_s ^ i_cpol;
      end else begin
         ev   = (state == mlsp_pkg::ST_SHIFT) && (half_cnt == half - 8'h01);
         lead = (sclk == i_cpol);
      end
      sample = lead ^ i_cpha;
      case (lanes)
         mlsp_pkg::LANES_2: beats2 = BEATS2_2;
         mlsp_pkg::LANES_4: beats2 = BEATS2_4;
         default:           beats2 = BEATS2_1;
      endcase
      target = slave_mode ? beats2 - {6'h00, !i_cpha} : beats2;
      case (lanes)
         mlsp_pkg::LANES_2: in_bits = {2'b00, lane_in[1:0]};
         mlsp_pkg::LANES_4: in_bits = lane_in;
         default:           in_bits = {3'b000, slave_mode ? lane_in[0] : lane_in[1]};
      endcase

      case (state)
         mlsp_pkg::ST_IDLE: begin
            next_half_cnt = '0;
            next_edge_cnt = '0;
            next_sclk     = i_cpol;
            if (!i_enable) begin
               next_lane_oe_n = mlsp_pkg::OE_ALL_RELEASED;
            end else if (slave_mode) begin
               next_lane_oe_n = sel ? mlsp_pkg::OE_LANE1 : mlsp_pkg::OE_ALL_RELEASED;
               if (sel) begin
                  // Head stays in the FIFO until done, so a retry resends it
                  next_state    = mlsp_pkg::ST_SHIFT;
                  next_lanes    = mlsp_pkg::LANES_1;
                  next_shift_tx = tx_valid ? (tx_head << TX_SHIFT) : '0;
               end
            end else begin
               if (&i_ss_value) begin
                  next_cmd_seen  = 1'b0;
                  next_lane_oe_n = mlsp_pkg::OE_LANE0;
               end
               if (tx_valid && rx_room) begin
                  tx_pop        = 1'b1;
                  next_state    = mlsp_pkg::ST_SHIFT;
                  next_shift_tx = tx_head << TX_SHIFT;
                  if (IS_STD) begin
                     next_lanes     = mlsp_pkg::LANES_1;
                     next_lane_oe_n = mlsp_pkg::OE_LANE0;
                  end else if (!cmd_seen) begin
                     // Command byte itself always goes out on one lane
                     next_plan = mlsp_pkg::decode_cmd(tx_head[mlsp_pkg::BYTE_W-1:0]);
                     if (BUILD == mlsp_pkg::BUILD_DUAL && next_plan.lanes == mlsp_pkg::LANES_4) begin
                        next_plan.lanes      = mlsp_pkg::LANES_1;
                        next_plan.addr_multi = 1'b0;
                     end
                     next_cmd_seen  = 1'b1;
                     next_elem_idx  = '0;
                     next_lanes     = mlsp_pkg::LANES_1;
                     next_lane_oe_n = mlsp_pkg::OE_LANE0;
                  end else begin
                     if (elem_idx < i_addr_bytes) begin
                        next_lanes     = plan.addr_multi ? plan.lanes : mlsp_pkg::LANES_1;
                        next_lane_oe_n = mlsp_pkg::lane_oe_for(next_lanes, 1'b1);
                     end else begin
                        next_lanes     = plan.lanes;
                        next_lane_oe_n = mlsp_pkg::lane_oe_for(plan.lanes, !plan.is_read);
                     end
                     if (elem_idx != 3'h7) next_elem_idx = elem_idx + 3'h1;
                  end
               end
            end
         end
         mlsp_pkg::ST_SHIFT: begin
            next_half_cnt = ev ? '0 : half_cnt + 8'h01;
            if (slave_mode && !sel) begin
               next_state = mlsp_pkg::ST_IDLE;
               next_abort = 1'b1;
            end else if (ev) begin
               next_edge_cnt = edge_cnt + 7'h01;
               if (!slave_mode) next_sclk = !sclk;
               if (sample) begin
                  next_shift_rx = (shift_rx << lanes) | XFER_WIDTH'(in_bits);
               end else if (!(lead && edge_cnt == '0)) begin
                  next_shift_tx = shift_tx << lanes;
               end
               if (next_edge_cnt == target) begin
                  rx_push    = 1'b1;
                  tx_pop     = slave_mode && tx_valid;
                  next_state = auto_ss ? mlsp_pkg::ST_GAP : mlsp_pkg::ST_IDLE;
                  next_half_cnt = '0;
               end
            end
         end
         mlsp_pkg::ST_GAP: begin
            next_half_cnt = half_cnt + 8'h01;
            if (half_cnt == half - 8'h01) begin
               next_state    = mlsp_pkg::ST_IDLE;
               next_half_cnt = '0;
            end
         end
         default: begin
            next_state = mlsp_pkg::ST_IDLE;
         end
      endcase

      rx_word = next_shift_rx & EW_MASK;
      // Select outputs: manual follows the value, automatic frames each element
      if (slave_mode || !i_enable) next_ss_out = '1;
      else if (auto_ss && next_state != mlsp_pkg::ST_SHIFT) next_ss_out = '1;
      else next_ss_out = i_ss_value;
      case (next_lanes)
         mlsp_pkg::LANES_2: next_lane_out = {2'b00, next_shift_tx[XFER_WIDTH-1 -: 2]};
         mlsp_pkg::LANES_4: next_lane_out = next_shift_tx[XFER_WIDTH-1 -: 4];
         default: next_lane_out = slave_mode ? {2'b00, next_shift_tx[XFER_WIDTH-1], 1'b0} :
                                               {3'b000, next_shift_tx[XFER_WIDTH-1]};
      endcase
      next_busy     = (next_state != mlsp_pkg::ST_IDLE);
      next_tx_empty = !tx_valid;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state     <= mlsp_pkg::ST_IDLE;
         plan      <= '0;
         shift_tx  <= '0;
         shift_rx  <= '0;
         edge_cnt  <= '0;
         half_cnt  <= '0;
         lanes     <= mlsp_pkg::LANES_1;
         elem_idx  <= '0;
         lane_oe_n <= mlsp_pkg::OE_ALL_RELEASED;
         lane_out  <= '0;
         ss_out    <= '1;
         sclk      <= 1'b0;
         sclk_d    <= 1'b1;
         cmd_seen  <= 1'b0;
         busy      <= 1'b0;
         tx_empty  <= 1'b1;
         abort     <= 1'b0;
      end else begin
         state     <= next_state;
         plan      <= next_plan;
         shift_tx  <= next_shift_tx;
         shift_rx  <= next_shift_rx;
         edge_cnt  <= next_edge_cnt;
         half_cnt  <= next_half_cnt;
         lanes     <= next_lanes;
         elem_idx  <= next_elem_idx;
         lane_oe_n <= next_lane_oe_n;
         lane_out  <= next_lane_out;
         ss_out    <= next_ss_out;
         sclk      <= next_sclk;
         sclk_d    <= next_sclk_d;
         cmd_seen  <= next_cmd_seen;
         busy      <= next_busy;
         tx_empty  <= next_tx_empty;
         abort     <= next_abort;
      end
   end

   assign o_sclk             = sclk;
   assign o_ss_n             = ss_out;
   assign o_serial_lane.out  = lane_out;
   assign o_serial_lane.oe_n = lane_oe_n;
   assign o_busy             = busy;
   assign o_tx_empty         = tx_empty;
   assign o_slave_abort      = abort;
endmodule
`default_nettype wire

//--- tb/mlsp_check_properties.sv
`default_nettype none
module mlsp_check #(
   parameter int NUM_SLAVES = 1
) (
   input wire logic                  i_sys_clk,
   input wire logic                  i_rst_n,
   input wire logic                  i_master,
   input wire logic                  i_cpol,
   input wire logic                  i_manual_ss,
   input wire logic                  i_slave_select_input_n,
   input wire logic                  o_busy,
   input wire logic                  o_tx_empty,
   input wire logic                  o_slave_abort,
   input wire logic                  o_sclk,
   input wire logic [NUM_SLAVES-1:0] i_ss_value,
   input wire logic [NUM_SLAVES-1:0] o_ss_n,
   input wire mlsp_pkg::lane_drive_t o_serial_lane
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   property p_idle;
      i_master && $past(i_rst_n) && !o_busy && !$past(o_busy) && $stable(i_cpol) |-> o_sclk == i_cpol;
   endproperty
   a_idle: assert property (p_idle) else $error("sclk off idle");
   property p_gate;
      $changed(o_sclk) && $past(i_cpol, 2) == i_cpol && $past(i_rst_n, 2) |-> o_busy || $past(o_busy);
   endproperty
   a_gate: assert property (p_gate) else $error("sclk moved while idle");
   property p_manual;
      o_busy && i_manual_ss && $stable(i_ss_value) |-> o_ss_n == i_ss_value;
   endproperty
   a_manual: assert property (p_manual) else $error("select off value");
   property p_stream;
      i_master && i_manual_ss && $fell(o_busy) ##1 !o_tx_empty [*2] |-> ##[0:2] o_busy;
   endproperty
   a_stream: assert property (p_stream) else $error("stream stalled");
   property p_auto;
      i_master && !i_manual_ss && $fell(o_ss_n[0]) |-> ##[1:200] $rose(o_ss_n[0]);
   endproperty
   a_auto: assert property (p_auto) else $error("auto select stuck");
   property p_abort;
      !i_master && o_busy && $rose(i_slave_select_input_n) |-> ##[1:5] o_slave_abort;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_pulse;
      o_slave_abort |=> !o_slave_abort;
   endproperty
   a_pulse: assert property (p_pulse) else $error("abort too long");
   property p_lanes;
      i_master && o_busy |-> o_serial_lane.oe_n == mlsp_pkg::OE_LANE0;
   endproperty
   a_lanes: assert property (p_lanes) else $error("lane drive wrong");
endmodule
bind multi_lane_serial_port_ctrl mlsp_check #(.NUM_SLAVES(NUM_SLAVES)) mlsp_check_inst (.*);
`default_nettype wire

//--- tb/mlsp_flash_model.sv
`default_nettype none
module mlsp_flash_model #(
   parameter logic [7:0] INIT = 8'ha5
) (
   input  wire logic i_sclk,
   input  wire logic i_cpol,
   input  wire logic i_cpha,
   input  wire logic i_ss_n,
   input  wire logic i_mosi,
   output logic      o_miso
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shreg = INIT;
   logic [2:0] n = 3'h0;
   logic       in_bit = 1'h0;
   // Rises on the sampling edge in either phase
   wire logic  take = i_sclk ^ i_cpol ^ i_cpha;
   // Echo slave: take on sampling edge, shift on the other one; phase 1
   // skips the first shift of a byte and shifts its last bit in at once
   always @(posedge take) if (!i_ss_n) begin
      in_bit <= i_mosi;
      n <= n + 3'h1;
      if (i_cpha && n == 3'h7) shreg <= {shreg[6:0], i_mosi};
   end
   always @(negedge take) if (!i_ss_n && (!i_cpha || n != 3'h0)) shreg <= {shreg[6:0], in_bit};
   // Deselected line shows the inverse of its last bit
   assign o_miso = i_ss_n ^ shreg[7];
endmodule
`default_nettype wire

//--- tb/multi_lane_serial_port_ctrl_tb_top.sv
`default_nettype none
module multi_lane_serial_port_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  i_sys_clk = 1'h0, i_rst_n = 1'h0, i_enable = 1'h1, i_master = 1'h1;
   logic                  i_cpol = 1'h0, i_cpha = 1'h0, i_manual_ss = 1'h1, i_tx_valid = 1'h0;
   logic                  i_rx_ready = 1'h0, i_sclk = 1'h0, i_slave_select_input_n = 1'h1;
   logic [1:0]            i_ss_value = 2'h3;
   logic [7:0]            i_half_period = 8'h04, i_tx_data = 8'h00;
   logic [2:0]            i_addr_bytes = 3'h0;
   logic [3:0]            i_serial_lane;
   logic                  o_tx_ready, o_rx_valid, o_busy, o_tx_empty, o_slave_abort;
   logic                  o_sclk, miso, ab;
   logic [7:0]            o_rx_data;
   logic [1:0]            o_ss_n;
   mlsp_pkg::lane_drive_t o_serial_lane;
   int                    err_count = 0, total_checks = 0;
   // Byte sent, byte received while sending it (the byte before, echoed)
   logic [15:0]           rows [4] = '{16'h3ca5, 16'h813c, 16'hff81, 16'h00ff};
   always #5 i_sys_clk = ~i_sys_clk;
   assign i_serial_lane = {2'h3, miso, o_serial_lane.out[0]};
   multi_lane_serial_port_ctrl #(.NUM_SLAVES(2), .FIFO_DEPTH(256))
      multi_lane_serial_port_ctrl_inst (.*);
   mlsp_flash_model mlsp_flash_model_inst (.i_sclk(o_sclk), .i_cpol, .i_cpha, .i_ss_n(o_ss_n[0]),
      .i_mosi(o_serial_lane.out[0]), .o_miso(miso));
   task automatic report_and_stop();
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic put(input logic [7:0] d);
      logic ok;
      i_tx_valid = 1'h1;
      i_tx_data = d;
      do begin
         ok = o_tx_ready;
         tick(1);
      end while (!ok);
   endtask
   task automatic get(input logic [7:0] e);
      int n = 0;
      while (o_rx_valid !== 1'h1 && n < 3000) begin
         tick(1);
         n++;
      end
      chk("rx", {o_rx_valid, o_rx_data}, {1'h1, e});
      i_rx_ready = 1'h1;
      tick(1);
      i_rx_ready = 1'h0;
      tick(1);
   endtask
   initial begin
      tick(4);
      chk("reset", {o_busy, o_tx_empty, o_sclk, o_ss_n, o_serial_lane.oe_n}, 16'h00bf);
      tick(6);
      i_rst_n = 1'h1;
      tick(2);
      i_ss_value = 2'h2;
      tick(2);
      foreach (rows[k]) put(rows[k][15:8]);
      i_tx_valid = 1'h0;
      foreach (rows[k]) get(rows[k][7:0]);
      i_ss_value = 2'h3;
      tick(2);
      i_cpol = 1'h1;
      tick(3);
      chk("idle", o_sclk, 1'h1);
      i_ss_value = 2'h2;
      tick(2);
      put(8'h5a);
      i_tx_valid = 1'h0;
      get(8'h00);
      i_ss_value = 2'h3;
      tick(2);
      i_manual_ss = 1'h0;
      i_cpha = 1'h1;
      i_ss_value = 2'h2;
      put(8'hc3);
      put(8'h18);
      i_tx_valid = 1'h0;
      get(8'h5a);
      get(8'hc3);
      i_master = 1'h0;
      put(8'h96);
      i_tx_valid = 1'h0;
      i_sclk = 1'h1;
      i_slave_select_input_n = 1'h0;
      tick(6);
      repeat (3) begin
         i_sclk = ~i_sclk;
         #80;
      end
      chk("slave bit", o_serial_lane.out[1], 1'h0);
      i_slave_select_input_n = 1'h1;
      ab = 1'h0;
      repeat (8) begin
         tick(1);
         ab = ab | o_slave_abort;
      end
      chk("abort", ab, 1'h1);
      i_sclk = 1'h1;
      i_slave_select_input_n = 1'h0;
      tick(6);
      chk("retry bit", o_serial_lane.out[1], 1'h1);
      report_and_stop();
   end
   initial begin
      #400000;
      err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
